// ### iepc_map.svh
// register offsets, field positions and reset values of the interrupt enable and priority block
`ifndef IEPC_MAP_SVH
`define IEPC_MAP_SVH

`define IEPC_ADDR_W 12
`define IEPC_DATA_W 8

`define IEPC_OFF_G2_HIGH 12'h0fc7
`define IEPC_OFF_G2_LOW 12'h0fc8
`define IEPC_OFF_EDGE_SEL 12'h0fcd
`define IEPC_OFF_SHARED_SEL 12'h0fce
`define IEPC_OFF_MASTER_CTL 12'h0fcf

`define IEPC_RST_BYTE 8'h00
`define IEPC_ZERO_BYTE 8'h00
`define IEPC_CTL_RSVD_ZERO 7'h00

`define IEPC_MIE_BIT 7
`define IEPC_CMP_CHOICE_BIT 6
`define IEPC_SHARED_LINE 6

`endif

// ### iepc_pkg.sv
// types shared by the interrupt enable and priority block
`default_nettype none
package iepc_pkg;
   typedef enum logic [1:0] {
      IEPC_LVL_OFF = 2'h0,
      IEPC_LVL_LOW = 2'h1,
      IEPC_LVL_NOM = 2'h2,
      IEPC_LVL_HIGH = 2'h3
   } iepc_level_t;
endpackage
`default_nettype wire

// ### iepc_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module iepc_sync
   import iepc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stable_r;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("sync width must be at least one");
      end
   endgenerate

   // first stage is read by the second stage only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         stable_r <= '0;
      end else begin
         meta_r <= asyncIn;
         stable_r <= meta_r;
      end
   end

   assign syncOut = stable_r;
endmodule
`default_nettype wire

// ### iepc_prio_arb.sv
// picks the highest enabled priority level among pending group sources
`timescale 1ns/1ps
`default_nettype none
module iepc_prio_arb
   import iepc_pkg::*;
#(
   parameter int NSRC = 4,
   parameter int IDX_W = 2
) (
   input wire logic [NSRC-1:0] pending,
   input wire logic [NSRC-1:0] enHigh,
   input wire logic [NSRC-1:0] enLow,
   input wire logic gateOpen,
   output logic hit,
   output iepc_level_t level,
   output logic [IDX_W-1:0] index
);

   generate
      if (NSRC < 1 || (1 << IDX_W) < NSRC) begin : g_bad_cfg
         $error("index width too small for source count");
      end
   endgenerate

   // lowest index wins a tie within one level
   always_comb begin
      hit = 1'b0;
      level = IEPC_LVL_OFF;
      index = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (gateOpen && pending[i] && {enHigh[i], enLow[i]} != IEPC_LVL_OFF &&
             {enHigh[i], enLow[i]} >= level) begin
            hit = 1'b1;
            level = iepc_level_t'({enHigh[i], enLow[i]});
            index = IDX_W'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ### iepc_ctrl.sv
// interrupt enable, priority, edge select, shared source and master enable control
// Behaviour
// - each group-2 source's high/low pair: 00 off, 01 low, 10 nominal, 11 high.
// - group-2 high enable bits 3..0 belong to port C lines 3..0.
// - group-2 low enable bits 3..0 belong to port C lines 3..0.
// - edge select bit 0 makes its pin interrupt fire on a falling edge.
// - edge select bit 1 makes its pin interrupt fire on a rising edge.
// - shared select bit 6: 0 takes line 6 of port A or port D as the port select picks, 1 the comparator.
// - a source switch that makes an edge raises a request like any edge.
// - master enable bit 7: 0 blocks every interrupt, 1 lets them through. Here it gates only the group-2 request; pinIrq_r pulses regardless.
// - enable or return instruction, or a written 1, sets the master enable.
// - disable instruction, acknowledge, reset or a written 0 clear it.
// - master control bits 6..0 read zero and ignore writes.
// - a port select input picks port A or port D for each pin interrupt.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "iepc_map.svh"
module iepc_ctrl
   import iepc_pkg::*;
#(
   parameter int NPIN = 8,
   parameter int NSRC = 4,
   parameter int IDX_W = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`IEPC_ADDR_W-1:0] regAddr,
   input wire logic [`IEPC_DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [`IEPC_DATA_W-1:0] regRdData_r,
   input wire logic enableInstr,
   input wire logic returnInstr,
   input wire logic disableInstr,
   input wire logic cpuAck,
   input wire logic [NPIN-1:0] portaPin,
   input wire logic [NPIN-1:0] portdPin,
   input wire logic comparatorOut,
   input wire logic [NPIN-1:0] portSelect,
   input wire logic [NSRC-1:0] group2Pending,
   output logic [NPIN-1:0] pinIrq_r,
   output logic masterEnable_r,
   output logic cpuIrqValid_r,
   output iepc_level_t cpuIrqLevel_r,
   output logic [IDX_W-1:0] cpuIrqSource_r
);

   generate
      if (NPIN != `IEPC_DATA_W) begin : g_bad_npin
         $error("pin count must match the register width");
      end
      if (NSRC < 1 || NSRC > `IEPC_DATA_W / 2) begin : g_bad_nsrc
         $error("group-2 source count out of range");
      end
   endgenerate

   // software-visible registers
   logic [`IEPC_DATA_W-1:0] group2EnableHigh_r;
   logic [`IEPC_DATA_W-1:0] group2EnableLow_r;
   logic [`IEPC_DATA_W-1:0] edgePolarity_r;
   logic [`IEPC_DATA_W-1:0] sharedSelect_r;
   logic masterEnable_nxt;

   // address decode
   logic hitG2High;
   logic hitG2Low;
   logic hitEdge;
   logic hitShared;
   logic hitCtl;

   assign hitG2High = (regAddr == `IEPC_OFF_G2_HIGH);
   assign hitG2Low = (regAddr == `IEPC_OFF_G2_LOW);
   assign hitEdge = (regAddr == `IEPC_OFF_EDGE_SEL);
   assign hitShared = (regAddr == `IEPC_OFF_SHARED_SEL);
   assign hitCtl = (regAddr == `IEPC_OFF_MASTER_CTL);

   // reserved bits are stored as written; software keeps them zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         group2EnableHigh_r <= `IEPC_RST_BYTE;
      end else if (regWr && hitG2High) begin
         group2EnableHigh_r <= regWrData;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         group2EnableLow_r <= `IEPC_RST_BYTE;
      end else if (regWr && hitG2Low) begin
         group2EnableLow_r <= regWrData;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         edgePolarity_r <= `IEPC_RST_BYTE;
      end else if (regWr && hitEdge) begin
         edgePolarity_r <= regWrData;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sharedSelect_r <= `IEPC_RST_BYTE;
      end else if (regWr && hitShared) begin
         sharedSelect_r <= regWrData;
      end
   end

   // master enable: instruction set beats any clear in the same cycle
   always_comb begin
      masterEnable_nxt = masterEnable_r;
      if (regWr && hitCtl) begin
         masterEnable_nxt = regWrData[`IEPC_MIE_BIT];
      end
      if (disableInstr || cpuAck) begin
         masterEnable_nxt = 1'b0;
      end
      if (enableInstr || returnInstr) begin
         masterEnable_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         masterEnable_r <= 1'b0;
      end else begin
         masterEnable_r <= masterEnable_nxt;
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdData_r <= `IEPC_ZERO_BYTE;
      end else if (!regRd) begin
         regRdData_r <= `IEPC_ZERO_BYTE;
      end else if (hitG2High) begin
         regRdData_r <= group2EnableHigh_r;
      end else if (hitG2Low) begin
         regRdData_r <= group2EnableLow_r;
      end else if (hitEdge) begin
         regRdData_r <= edgePolarity_r;
      end else if (hitShared) begin
         regRdData_r <= sharedSelect_r;
      end else if (hitCtl) begin
         regRdData_r <= {masterEnable_r, `IEPC_CTL_RSVD_ZERO};
      end else begin
         regRdData_r <= `IEPC_ZERO_BYTE;
      end
   end

   // pins come from outside the clock domain
   logic [NPIN-1:0] portaSync;
   logic [NPIN-1:0] portdSync;
   logic [0:0] comparatorSync;

   iepc_sync #(.WIDTH(NPIN)) u_sync_porta (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(portaPin),
      .syncOut(portaSync)
   );

   iepc_sync #(.WIDTH(NPIN)) u_sync_portd (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(portdPin),
      .syncOut(portdSync)
   );

   iepc_sync #(.WIDTH(1)) u_sync_cmp (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(comparatorOut),
      .syncOut(comparatorSync)
   );

   // edge detection sits after the source muxes, so a source switch
   // that changes the level is seen as an edge on purpose
   logic [NPIN-1:0] selectedLine;
   logic [NPIN-1:0] lastLine_r;
   logic [NPIN-1:0] riseSeen;
   logic [NPIN-1:0] fallSeen;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         if (gi == `IEPC_SHARED_LINE) begin : g_shared
            assign selectedLine[gi] = sharedSelect_r[`IEPC_CMP_CHOICE_BIT] ? comparatorSync[0] :
                                      (portSelect[gi] ? portdSync[gi] : portaSync[gi]);
         end else begin : g_plain
            assign selectedLine[gi] = portSelect[gi] ? portdSync[gi] : portaSync[gi];
         end

         assign riseSeen[gi] = selectedLine[gi] && !lastLine_r[gi];
         assign fallSeen[gi] = !selectedLine[gi] && lastLine_r[gi];

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               lastLine_r[gi] <= 1'b0;
               pinIrq_r[gi] <= 1'b0;
            end else begin
               lastLine_r[gi] <= selectedLine[gi];
               // one-cycle request pulse per qualifying edge
               pinIrq_r[gi] <= edgePolarity_r[gi] ? riseSeen[gi] : fallSeen[gi];
            end
         end

         property p_fall_edge;
            @(posedge clk) disable iff (!resetn)
               (!edgePolarity_r[gi] && fallSeen[gi]) |=> pinIrq_r[gi];
         endproperty
         a_fall_edge: assert property (p_fall_edge)
            else $error("falling edge missed");

         property p_rise_edge;
            @(posedge clk) disable iff (!resetn)
               (edgePolarity_r[gi] && $rose(selectedLine[gi])) |=> pinIrq_r[gi];
         endproperty
         a_rise_edge: assert property (p_rise_edge)
            else $error("rising edge missed");

         property p_wrong_edge;
            @(posedge clk) disable iff (!resetn)
               (!edgePolarity_r[gi] && riseSeen[gi]) |=> !pinIrq_r[gi];
         endproperty
         a_wrong_edge: assert property (p_wrong_edge)
            else $error("rising edge fired on falling polarity");
      end
   endgenerate

   // group-2 priority selection
   logic arbHit;
   iepc_level_t arbLevel;
   logic [IDX_W-1:0] arbIndex;

   iepc_prio_arb #(.NSRC(NSRC), .IDX_W(IDX_W)) u_arb (
      .pending(group2Pending),
      .enHigh(group2EnableHigh_r[NSRC-1:0]),
      .enLow(group2EnableLow_r[NSRC-1:0]),
      .gateOpen(masterEnable_r),
      .hit(arbHit),
      .level(arbLevel),
      .index(arbIndex)
   );

   // the request is dropped at once when the cpu acknowledges it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpuIrqValid_r <= 1'b0;
         cpuIrqLevel_r <= IEPC_LVL_OFF;
         cpuIrqSource_r <= '0;
      end else begin
         cpuIrqValid_r <= arbHit && !cpuAck;
         cpuIrqLevel_r <= arbHit ? arbLevel : IEPC_LVL_OFF;
         cpuIrqSource_r <= arbIndex;
      end
   end

   property p_level_nonzero;
      @(posedge clk) disable iff (!resetn)
         cpuIrqValid_r |-> (cpuIrqLevel_r != IEPC_LVL_OFF);
   endproperty
   a_level_nonzero: assert property (p_level_nonzero)
      else $error("request forwarded at disabled level");

   property p_high_write;
      @(posedge clk) disable iff (!resetn)
         (regWr && hitG2High) ##1 regRd && hitG2High |=> (regRdData_r == $past(group2EnableHigh_r));
   endproperty
   a_high_write: assert property (p_high_write)
      else $error("high enable readback wrong");

   property p_low_store;
      @(posedge clk) disable iff (!resetn)
         (regWr && hitG2Low) |=> (group2EnableLow_r == $past(regWrData));
   endproperty
   a_low_store: assert property (p_low_store)
      else $error("low enable not stored");

   property p_cmp_route;
      @(posedge clk) disable iff (!resetn)
         (sharedSelect_r[`IEPC_CMP_CHOICE_BIT] && $stable(sharedSelect_r) && edgePolarity_r[`IEPC_SHARED_LINE]
          && $rose(comparatorSync[0])) |=> pinIrq_r[`IEPC_SHARED_LINE];
   endproperty
   a_cmp_route: assert property (p_cmp_route)
      else $error("comparator edge not routed");

   property p_shared_switch;
      @(posedge clk) disable iff (!resetn)
         ($changed(sharedSelect_r[`IEPC_CMP_CHOICE_BIT]) && !edgePolarity_r[`IEPC_SHARED_LINE]
          && fallSeen[`IEPC_SHARED_LINE]) |=> pinIrq_r[`IEPC_SHARED_LINE];
   endproperty
   a_shared_switch: assert property (p_shared_switch)
      else $error("source switch edge not raised");

   property p_master_block;
      @(posedge clk) disable iff (!resetn)
         !masterEnable_r |=> !cpuIrqValid_r;
   endproperty
   a_master_block: assert property (p_master_block)
      else $error("request passed while masked");

   property p_master_set;
      @(posedge clk) disable iff (!resetn)
         (enableInstr || returnInstr) |=> masterEnable_r;
   endproperty
   a_master_set: assert property (p_master_set)
      else $error("master enable not set");

   property p_master_clear;
      @(posedge clk) disable iff (!resetn)
         ((disableInstr || cpuAck) && !enableInstr && !returnInstr) |=> !masterEnable_r;
   endproperty
   a_master_clear: assert property (p_master_clear)
      else $error("master enable not cleared");

   // a register write only counts when no instruction or acknowledge competes
   property p_master_write;
      @(posedge clk) disable iff (!resetn)
         (regWr && hitCtl && !enableInstr && !returnInstr && !disableInstr && !cpuAck)
            |=> (masterEnable_r == $past(regWrData[`IEPC_MIE_BIT]));
   endproperty
   a_master_write: assert property (p_master_write)
      else $error("master enable write lost");

   property p_ctl_read;
      @(posedge clk) disable iff (!resetn)
         (regRd && hitCtl) |=> (regRdData_r == {$past(masterEnable_r), `IEPC_CTL_RSVD_ZERO});
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("control readback wrong");

   property p_winner;
      @(posedge clk) disable iff (!resetn)
         cpuIrqValid_r |-> (cpuIrqLevel_r == $past(arbLevel)) && $past(masterEnable_r);
   endproperty
   a_winner: assert property (p_winner)
      else $error("forwarded level differs from arbiter");

endmodule
`default_nettype wire

// ### iepc_cpu_model.sv
// processor core model: runs interrupt instructions and acknowledges requests
`timescale 1ns/1ps
`default_nettype none
module iepc_cpu_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cpuIrqValid_r,
   input wire logic ackOn,
   input wire logic [3:0] ackDelay,
   output logic enableInstr,
   output logic returnInstr,
   output logic disableInstr,
   output logic cpuAck
);
   logic [3:0] waitCnt;
   initial begin
      enableInstr = 1'b0;
      returnInstr = 1'b0;
      disableInstr = 1'b0;
   end
   // code 0 enable, 1 return, 2 disable; one cycle each
   task automatic instr(input int code);
      @(posedge clk);
      enableInstr <= (code == 0);
      returnInstr <= (code == 1);
      disableInstr <= (code == 2);
      @(posedge clk);
      enableInstr <= 1'b0;
      returnInstr <= 1'b0;
      disableInstr <= 1'b0;
   endtask
   // ackDelay lets the core answer promptly or late; one ack per request
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpuAck <= 1'b0;
         waitCnt <= 4'h0;
      end else begin
         cpuAck <= 1'b0;
         if (ackOn && cpuIrqValid_r && !cpuAck) begin
            if (waitCnt == ackDelay) begin
               cpuAck <= 1'b1;
               waitCnt <= 4'h0;
            end else begin
               waitCnt <= waitCnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### iepc_ctrl_test.sv
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "iepc_map.svh"
module iepc_ctrl_test;
   import iepc_pkg::*;
   logic clk, resetn, regWr, regRd, comparatorOut, ackOn;
   logic enableInstr, returnInstr, disableInstr, cpuAck, masterEnable_r, cpuIrqValid_r;
   logic [`IEPC_ADDR_W-1:0] regAddr;
   logic [7:0] regWrData, regRdData_r, portaPin, portdPin, portSelect, pinIrq_r;
   logic [3:0] group2Pending, ackDelay;
   logic [1:0] cpuIrqSource_r;
   iepc_level_t cpuIrqLevel_r;
   int badCount, checkCount, cyc;

   iepc_ctrl i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r), .enableInstr(enableInstr),
      .returnInstr(returnInstr), .disableInstr(disableInstr), .cpuAck(cpuAck),
      .portaPin(portaPin), .portdPin(portdPin), .comparatorOut(comparatorOut),
      .portSelect(portSelect), .group2Pending(group2Pending), .pinIrq_r(pinIrq_r),
      .masterEnable_r(masterEnable_r), .cpuIrqValid_r(cpuIrqValid_r),
      .cpuIrqLevel_r(cpuIrqLevel_r), .cpuIrqSource_r(cpuIrqSource_r));
   iepc_cpu_model i_cpu (.clk(clk), .resetn(resetn), .cpuIrqValid_r(cpuIrqValid_r),
      .ackOn(ackOn), .ackDelay(ackDelay), .enableInstr(enableInstr), .returnInstr(returnInstr),
      .disableInstr(disableInstr), .cpuAck(cpuAck));

   always #2.5 clk = ~clk;

   task automatic reportAndStop();
      if (badCount == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // a whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         badCount++;
         reportAndStop();
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk("read data", regRdData_r, exp);
   endtask

   // write then read with no gap between the strobes
   task automatic wrRd(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk("read data", regRdData_r, d);
   endtask

   // counts request pulses of one line over six cycles
   task automatic pulses(input int l, input int exp);
      int n = 0;
      repeat (6) begin
         @(posedge clk);
         #1 if (pinIrq_r[l] === 1'b1) n++;
      end
      chk("pin request count", 8'(n), 8'(exp));
      @(posedge clk);
   endtask

   task automatic testRegs();
      logic [11:0] offs[6] = '{`IEPC_OFF_G2_HIGH, `IEPC_OFF_G2_LOW, `IEPC_OFF_EDGE_SEL,
         `IEPC_OFF_SHARED_SEL, `IEPC_OFF_MASTER_CTL, 12'h0fc9};
      logic [7:0] vals[6] = '{8'h0f, 8'h05, 8'ha5, 8'h40, 8'h80, 8'h3c};
      foreach (offs[i]) rd(offs[i], 8'h00);
      // reserved bits written as zero by software
      foreach (offs[i]) wr(offs[i], vals[i]);
      foreach (offs[i]) rd(offs[i], (i == 5) ? 8'h00 : vals[i]);
      chk("master enable", 8'(masterEnable_r), 8'h01);
      wrRd(`IEPC_OFF_G2_HIGH, 8'h0c);
      foreach (offs[i]) wr(offs[i], 8'h00);
      rd(`IEPC_OFF_MASTER_CTL, 8'h00);
   endtask

   task automatic testInstr();
      int codes[4] = '{0, 2, 1, 2};
      foreach (codes[i]) begin
         i_cpu.instr(codes[i]);
         #1 chk("master enable", 8'(masterEnable_r), 8'(codes[i] != 2));
      end
   endtask

   task automatic level(input logic [7:0] hi, input logic [7:0] lo, input logic [3:0] pend,
      input logic [1:0] lvl, input logic [1:0] src);
      wr(`IEPC_OFF_G2_HIGH, hi);
      wr(`IEPC_OFF_G2_LOW, lo);
      group2Pending <= pend;
      repeat (2) @(posedge clk);
      #1 chk("request valid", 8'(cpuIrqValid_r), 8'(lvl != 2'h0));
      chk("request level", 8'(cpuIrqLevel_r), 8'(lvl));
      if (lvl != 2'h0) chk("request source", 8'(cpuIrqSource_r), 8'(src));
   endtask

   task automatic testLevels();
      i_cpu.instr(0);
      for (int v = 0; v < 4; v++) begin
         level(8'(v[1]) << 1, 8'(v[0]) << 1, 4'h2, 2'(v), 2'h1);
      end
      level(8'h08, 8'h09, 4'h9, 2'h3, 2'h3);
      level(8'h03, 8'h03, 4'h3, 2'h3, 2'h0);
      i_cpu.instr(2);
      repeat (2) @(posedge clk);
      #1 chk("request valid", 8'(cpuIrqValid_r), 8'h00);
      for (int d = 0; d < 4; d += 3) begin
         int n = 0;
         ackDelay <= 4'(d);
         ackOn <= 1'b1;
         i_cpu.instr(1);
         #1 chk("master enable", 8'(masterEnable_r), 8'h01);
         while (masterEnable_r !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1 n++;
         end
         chk("master enable", 8'(masterEnable_r), 8'h00);
         chk("request valid", 8'(cpuIrqValid_r), 8'h00);
         chk("ack cycles", 8'(n), 8'(3 + d));
      end
      ackOn <= 1'b0;
      i_cpu.instr(0);
      // let the request reach the core before reset hits it
      repeat (2) @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("master enable", 8'(masterEnable_r), 8'h00);
      chk("request valid", 8'(cpuIrqValid_r), 8'h00);
      chk("request level", 8'(cpuIrqLevel_r), 8'h00);
      @(posedge clk);
      resetn <= 1'b1;
      group2Pending <= 4'h0;
      rd(`IEPC_OFF_G2_HIGH, 8'h00);
   endtask

   task automatic edgeCase(input int l, input bit useD, input bit pol, input bit rise, input int exp);
      wr(`IEPC_OFF_EDGE_SEL, 8'(pol) << l);
      portSelect[l] <= useD;
      if (useD) portdPin[l] <= !rise;
      else portaPin[l] <= !rise;
      repeat (6) @(posedge clk);
      if (useD) portdPin[l] <= rise;
      else portaPin[l] <= rise;
      pulses(l, exp);
   endtask

   task automatic testPins();
      edgeCase(2, 1'b0, 1'b0, 1'b0, 1);
      edgeCase(5, 1'b1, 1'b0, 1'b1, 0);
      edgeCase(0, 1'b0, 1'b1, 1'b1, 1);
      edgeCase(7, 1'b1, 1'b1, 1'b0, 0);
      edgeCase(3, 1'b1, 1'b1, 1'b1, 1);
      wr(`IEPC_OFF_EDGE_SEL, 8'h40);
      wr(`IEPC_OFF_SHARED_SEL, 8'h40);
      repeat (4) @(posedge clk);
      comparatorOut <= 1'b1;
      pulses(6, 1);
      portaPin[6] <= 1'b1;
      pulses(6, 0);
      portaPin[6] <= 1'b0;
      pulses(6, 0);
      wr(`IEPC_OFF_EDGE_SEL, 8'h00);
      // switching line 6 from the comparator (high) back to port A (low) is a falling edge: one request
      wr(`IEPC_OFF_SHARED_SEL, 8'h00);
      pulses(6, 1);
   endtask

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = '0;
      regWrData = 8'h00;
      portaPin = 8'h00;
      portdPin = 8'h00;
      portSelect = 8'h00;
      comparatorOut = 1'b0;
      group2Pending = 4'h0;
      ackOn = 1'b0;
      ackDelay = 4'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      testRegs();
      testInstr();
      testLevels();
      testPins();
      reportAndStop();
   end
endmodule
`default_nettype wire
